// ==== hw/ssp_fifo.sv ====
// word fifo with valid/ready on both sides
// assumes ref_clk domain and synchronous active high reset
`timescale 1ns/1ps
module ssp_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // streams
    ssp_stream_if.snk in_s,
    ssp_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] level;
    logic push;
    logic pop;

    // ==========================================================
    // handshakes
    assign in_s.ready = 32'(level) != DEPTH;
    assign out_s.valid = level != '0;
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // storage, written only on an accepted word
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    full_block_a: assert property (@(posedge ref_clk) disable iff (rst)
        (32'(level) == DEPTH) |-> !in_s.ready ##1 (32'(level) >= DEPTH - 1))
        else $error("fifo accepted a word while full");
endmodule

// ==== hw/ssp_pkg.sv ====
// shared constants and types of the synchronous serial port
// assumes a single clock domain; pins sampled synchronously by the user
package ssp_pkg;
    // ==========================================================
    // sizes
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 5;
    localparam logic [3:0] SIZE_MIN = 4'h3;
    localparam logic [4:0] CMD_LEN = 5'h08;
    // ==========================================================
    // frame formats
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_SSF = 2'h1;
    localparam logic [1:0] FMT_CMD = 2'h2;
    // ==========================================================
    // engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SYNC = 4'h2,
        ST_XFER = 4'h4,
        ST_GAP = 4'h8
    } ssp_state_t;
endpackage

// ==== hw/ssp_skid.sv ====
// two entry buffer: a stalled reader never costs a word
// assumes ref_clk domain and synchronous active high reset
`timescale 1ns/1ps
module ssp_skid #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // streams
    ssp_stream_if.snk in_s,
    ssp_stream_if.src out_s
);
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0] fill;
    logic push;
    logic pop;

    // ==========================================================
    // handshakes
    assign in_s.ready = fill != 2'h2;
    assign out_s.valid = fill != 2'h0;
    assign out_s.data = slot0;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // slot0 is the head; slot1 only holds a word while the reader stalls
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fill <= 2'h0;
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            fill <= fill + 2'(push) - 2'(pop);
            if (pop) begin
                slot0 <= (fill == 2'h2) ? slot1 : in_s.data;
            end else if (push && fill == 2'h0) begin
                slot0 <= in_s.data;
            end
            if (push && (fill - 2'(pop)) == 2'h1) begin
                slot1 <= in_s.data;
            end
        end
    end
endmodule

// ==== hw/ssp_stream_if.sv ====
// valid/ready word stream between the port's own modules
// assumes both ends on the same clock
`timescale 1ns/1ps
interface ssp_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hw/ssp_top.sv ====
// synchronous serial port: fifos, clock divider and shift engine
// assumes pin inputs already synchronous to ref_clk; no software registers
`timescale 1ns/1ps
module ssp_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire logic enable,
    input wire logic master,
    input wire logic [1:0] frame_fmt,
    input wire logic [3:0] data_size,
    input wire logic clk_pol,
    input wire logic clk_pha,
    input wire logic slave_out_dis,
    input wire logic [7:0] prescale,
    input wire logic [7:0] rate_div,
    // transmit words in
    input wire logic [15:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // receive words out
    output logic [15:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // status
    output logic busy,
    output logic rx_overrun,
    // serial pins
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sclk_in,
    output logic fss_out,
    output logic fss_oe,
    input wire logic fss_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic rxd_in
);
    localparam int W = ssp_pkg::DATA_W;
    ssp_stream_if #(.W(W)) tx_in_s ();
    ssp_stream_if #(.W(W)) tx_out_s ();
    ssp_stream_if #(.W(W)) rx_in_s ();
    ssp_stream_if #(.W(W)) rx_mid_s ();
    ssp_stream_if #(.W(W)) rx_out_s ();

    ssp_pkg::ssp_state_t st;
    logic [7:0] pre_cnt;
    logic [7:0] div_cnt;
    logic pre_hit;
    logic tick;
    logic sclk_q;
    logic sclk_p;
    logic fss_q;
    logic fss_p;
    logic [W-1:0] tx_sr;
    logic [W-1:0] rx_sr;
    logic [W-1:0] rx_shift;
    logic [W-1:0] rx_word;
    logic rx_push;
    logic [ssp_pkg::CNT_W-1:0] cnt;
    logic [ssp_pkg::CNT_W-1:0] len;
    logic [ssp_pkg::CNT_W-1:0] total;
    logic is_cmd;
    logic eff_cpol;
    logic eff_cpha;
    logic ev_a;
    logic ev_b;
    logic smp;
    logic lnch;
    logic rx_en;
    logic done;
    logic start_m;
    logic start_s;
    logic abort_s;
    logic load;
    logic [W-1:0] word;

    // ==========================================================
    // buffers
    assign tx_in_s.valid = tx_valid;
    assign tx_in_s.data = tx_data;
    assign tx_ready = tx_in_s.ready;
    assign rx_in_s.valid = rx_push;
    assign rx_in_s.data = rx_word;
    assign rx_valid = rx_out_s.valid;
    assign rx_data = rx_out_s.data;
    assign rx_out_s.ready = rx_ready;

    ssp_fifo #(.W(W), .DEPTH(ssp_pkg::FIFO_DEPTH)) u_tx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_s(tx_in_s),
        .out_s(tx_out_s)
    );
    ssp_fifo #(.W(W), .DEPTH(ssp_pkg::FIFO_DEPTH)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_s(rx_in_s),
        .out_s(rx_mid_s)
    );
    ssp_skid #(.W(W)) u_rx_skid (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_s(rx_mid_s),
        .out_s(rx_out_s)
    );

    // ==========================================================
    // format decode; sync frame and command formats fix the clock shape
    assign is_cmd = frame_fmt == ssp_pkg::FMT_CMD;
    assign eff_cpol = (frame_fmt == ssp_pkg::FMT_SPI) ? clk_pol : 1'b0;
    assign eff_cpha = (frame_fmt == ssp_pkg::FMT_SPI) ? clk_pha : (frame_fmt == ssp_pkg::FMT_SSF);
    // sizes below four bits are raised to four
    assign len = {1'b0, (data_size < ssp_pkg::SIZE_MIN) ? ssp_pkg::SIZE_MIN : data_size} + 5'h01;
    assign total = is_cmd ? len + ssp_pkg::CMD_LEN : len;

    // ==========================================================
    // bit rate: half period is prescale * (rate_div + 1) clocks
    assign pre_hit = ({1'b0, pre_cnt} + 9'h001) >= {1'b0, prescale};
    assign tick = pre_hit && div_cnt == rate_div;

    always_ff @(posedge ref_clk) begin
        if (rst || !master || st == ssp_pkg::ST_IDLE) begin
            pre_cnt <= 8'h00;
            div_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_hit ? 8'h00 : pre_cnt + 8'h01;
            if (pre_hit) begin
                div_cnt <= (div_cnt == rate_div) ? 8'h00 : div_cnt + 8'h01;
            end
        end
    end

    // slave pins: previous copies give edges of the outside clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_q <= 1'b0;
            sclk_p <= 1'b0;
            fss_q <= 1'b1;
            fss_p <= 1'b1;
        end else begin
            sclk_q <= sclk_in;
            sclk_p <= sclk_q;
            fss_q <= fss_in;
            fss_p <= fss_q;
        end
    end

    // ==========================================================
    // edge events: a leaves idle polarity, b returns to it
    always_comb begin
        if (master) begin
            ev_a = tick && (st == ssp_pkg::ST_SYNC || st == ssp_pkg::ST_XFER) && sclk_out == eff_cpol;
            ev_b = tick && (st == ssp_pkg::ST_SYNC || st == ssp_pkg::ST_XFER) && sclk_out != eff_cpol;
        end else begin
            ev_a = sclk_q != sclk_p && sclk_q != eff_cpol;
            ev_b = sclk_q != sclk_p && sclk_q == eff_cpol;
        end
    end

    assign smp = st == ssp_pkg::ST_XFER && (eff_cpha ? ev_b : ev_a);
    // with late phase the first bit is already on the wire at load
    assign lnch = st == ssp_pkg::ST_XFER && (eff_cpha ? (ev_a && cnt != '0) : ev_b);
    // command format listens only after the command bits
    assign rx_en = !is_cmd || cnt >= ssp_pkg::CMD_LEN;
    assign done = st == ssp_pkg::ST_XFER && ev_b && (eff_cpha ? cnt + 5'h01 == total : cnt == total);
    assign rx_shift = {rx_sr[W-2:0], rxd_in};

    // master waits for rx room so a stalled reader stalls the link
    assign start_m = enable && master && st == ssp_pkg::ST_IDLE && tx_out_s.valid
        && rx_in_s.ready && !rx_push;
    assign start_s = enable && !master && st == ssp_pkg::ST_IDLE && fss_p && !fss_q;
    assign abort_s = !master && st == ssp_pkg::ST_XFER && fss_q && frame_fmt != ssp_pkg::FMT_SSF;
    assign load = start_m || start_s;
    assign tx_out_s.ready = load;
    // an empty fifo sends zeros when an outside master calls
    assign word = tx_out_s.valid ? tx_out_s.data : '0;

    // ==========================================================
    // frame sequencer and frame select
    always_ff @(posedge ref_clk) begin
        if (rst || !enable) begin
            st <= ssp_pkg::ST_IDLE;
            fss_out <= frame_fmt != ssp_pkg::FMT_SSF;
        end else begin
            unique case (st)
                ssp_pkg::ST_IDLE: begin
                    if (start_m && frame_fmt == ssp_pkg::FMT_SSF) begin
                        st <= ssp_pkg::ST_SYNC;
                        fss_out <= 1'b1;
                    end else if (load) begin
                        st <= ssp_pkg::ST_XFER;
                        fss_out <= frame_fmt == ssp_pkg::FMT_SSF;
                    end else begin
                        fss_out <= frame_fmt != ssp_pkg::FMT_SSF;
                    end
                end
                ssp_pkg::ST_SYNC: begin
                    if (ev_b) begin
                        st <= ssp_pkg::ST_XFER;
                        fss_out <= 1'b0;
                    end
                end
                ssp_pkg::ST_XFER: begin
                    if (abort_s) begin
                        st <= ssp_pkg::ST_IDLE;
                    end else if (done) begin
                        st <= master ? ssp_pkg::ST_GAP : ssp_pkg::ST_IDLE;
                        fss_out <= frame_fmt != ssp_pkg::FMT_SSF;
                    end
                end
                ssp_pkg::ST_GAP: begin
                    if (tick) begin
                        st <= ssp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // master serial clock toggles on divider ticks only
    always_ff @(posedge ref_clk) begin
        if (rst || st == ssp_pkg::ST_IDLE || st == ssp_pkg::ST_GAP) begin
            sclk_out <= eff_cpol;
        end else if (tick) begin
            sclk_out <= !sclk_out;
        end
    end

    // shift registers and bit count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_sr <= '0;
            rx_sr <= '0;
            cnt <= '0;
        end else if (load) begin
            // words leave msb first, left aligned to the frame length; command format sends the low byte only
            tx_sr <= is_cmd ? {word[7:0], 8'h00} : word << (5'(W) - len);
            rx_sr <= '0;
            cnt <= '0;
        end else begin
            if (smp) begin
                cnt <= cnt + 5'h01;
                if (rx_en) begin
                    rx_sr <= rx_shift;
                end
            end
            if (lnch) begin
                tx_sr <= {tx_sr[W-2:0], 1'b0};
            end
        end
    end

    // finished word to the receive fifo; a slave cannot wait, so it may drop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_push <= 1'b0;
            rx_word <= '0;
            rx_overrun <= 1'b0;
        end else begin
            rx_push <= done && rx_in_s.ready;
            rx_overrun <= done && !rx_in_s.ready;
            if (done) begin
                rx_word <= (smp && rx_en) ? rx_shift : rx_sr;
            end
        end
    end

    // ==========================================================
    // pins and status
    assign txd_out = tx_sr[W-1];
    assign sclk_oe = enable && master;
    assign fss_oe = enable && master;
    // slave drives only inside its frame and may stay silent
    assign txd_oe = enable && (master || (st == ssp_pkg::ST_XFER && !slave_out_dis))
        && !(is_cmd && st == ssp_pkg::ST_XFER && cnt >= ssp_pkg::CMD_LEN);
    assign busy = st != ssp_pkg::ST_IDLE;

    // ==========================================================
    // checks
    sync_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        st == ssp_pkg::ST_SYNC |-> fss_out && master)
        else $error("sync state without frame pulse");
    frame_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        done |-> (eff_cpha ? cnt + 5'h01 : cnt) == total && total >= 5'h04)
        else $error("frame ended at wrong bit count");
    shift_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        lnch && !load |=> txd_out == $past(tx_sr[W-2]))
        else $error("transmit bit not shifted");
    master_pins_a: assert property (@(posedge ref_clk) disable iff (rst)
        !master |-> !sclk_oe && !fss_oe && st != ssp_pkg::ST_SYNC)
        else $error("slave drove clock or frame");
    slave_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        !master && slave_out_dis |-> !txd_oe)
        else $error("silent slave drove data");
    rate_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
        master && st == ssp_pkg::ST_XFER && !tick ##1 st == ssp_pkg::ST_XFER |-> $stable(sclk_out))
        else $error("serial clock moved without a tick");
    duplex_a: assert property (@(posedge ref_clk) disable iff (rst)
        enable && master && frame_fmt == ssp_pkg::FMT_SPI |-> txd_oe && sclk_oe && fss_oe)
        else $error("spi master not driving all wires");
    slave_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
        !master && smp |-> sclk_q != sclk_p && (sclk_q == eff_cpol) == eff_cpha)
        else $error("slave sampled without a clock edge");
endmodule

// ==== sim/ssp_peer_model.sv ====
// spi style peripheral on the far side of the port, clock idle low, early sampling
// assumes sclk and fss come from the port; sclk stands still outside frames
`timescale 1ns/1ps
module ssp_peer_model (
    // link pins
    input wire logic ref_clk,
    input wire logic sclk,
    input wire logic fss,
    input wire logic mosi,
    output logic miso,
    // reply word and capture
    input wire logic [15:0] reply,
    input wire logic [4:0] len,
    output logic [15:0] got,
    output logic [4:0] nbits
);
    // ==========================================================
    // state
    logic [4:0] idx = 5'h00;
    logic tog = 1'b0;
    logic fss_was = 1'b1;
    logic [15:0] log_q[$];
    initial got = 16'h0000;
    initial nbits = 5'h00;
    // released line shows a changing pattern, never a held value
    always @(posedge ref_clk) begin
        tog <= ~tog;
    end
    // reply bit moves on the falling clock, restarts while deselected
    always @(negedge sclk or posedge fss) begin
        if (fss) begin
            idx <= 5'h00;
        end else begin
            idx <= idx + 5'h01;
        end
    end
    assign miso = (fss || idx >= len) ? tog : reply[len - 5'h01 - idx];
    // capture on rising clock inside a frame; a select change is handled on its own,
    // so a clock edge moving in the same step is never taken for a data bit
    always @(posedge sclk or fss) begin
        if (fss !== fss_was) begin
            fss_was = fss;
            if (!fss) begin
                nbits <= 5'h00;
            end
        end else if (!fss) begin
            got <= {got[14:0], mosi};
            nbits <= nbits + 5'h01;
        end
    end
    // keep each frame's word for order checks
    always @(posedge fss) begin
        log_q.push_back(got & (16'hffff >> (16 - len)));
    end
endmodule

// ==== sim/test_synchronous_serial_port.sv ====
// self-checking bench of the serial port: master, slave, buffering and formats
// assumes the peer model file compiled before this one
`timescale 1ns/1ps
module test_synchronous_serial_port;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b1;
    logic master = 1'b1;
    logic [1:0] frame_fmt = 2'h0;
    logic [3:0] data_size = 4'hf;
    logic slave_out_dis = 1'b0;
    logic [7:0] prescale = 8'h01;
    logic [7:0] rate_div = 8'h00;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic sclk_drv = 1'b0;
    logic fss_drv = 1'b1;
    logic rxd_drv = 1'b0;
    logic tog = 1'b0;
    logic [15:0] peer_word = 16'h0000;
    logic [4:0] peer_len = 5'h10;
    logic tx_ready, rx_valid, busy, rx_overrun, sclk_out, sclk_oe, fss_out, fss_oe;
    logic txd_out, txd_oe, miso, sclk_w, fss_w, mosi_w, rxd_w, sclk_q;
    logic ssf_hi = 1'b0;
    logic cmd_rel = 1'b0;
    logic ovr_seen = 1'b0;
    logic [15:0] rx_data, got, hp_last;
    logic [15:0] hp_cnt = 16'h0000;
    logic [4:0] nbits;
    logic [31:0] seed = 32'h0000_6dd5;
    int mismatches = 0;
    int total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) tog <= ~tog;
    // pins as seen at the board: the port drives clock and select only as master
    assign sclk_w = master ? sclk_out : sclk_drv;
    assign fss_w = master ? fss_out : fss_drv;
    assign mosi_w = txd_oe ? txd_out : tog;
    assign rxd_w = master ? miso : (fss_drv ? tog : rxd_drv);
    ssp_top u_ssp_top (.ref_clk(ref_clk), .rst(rst), .enable(enable), .master(master),
        .frame_fmt(frame_fmt), .data_size(data_size), .clk_pol(1'b0), .clk_pha(1'b0),
        .slave_out_dis(slave_out_dis), .prescale(prescale), .rate_div(rate_div),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .busy(busy), .rx_overrun(rx_overrun),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sclk_in(sclk_w), .fss_out(fss_out),
        .fss_oe(fss_oe), .fss_in(fss_w), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_w));
    ssp_peer_model u_peer (.ref_clk(ref_clk), .sclk(sclk_w), .fss(fss_w), .mosi(mosi_w),
        .miso(miso), .reply(peer_word), .len(peer_len), .got(got), .nbits(nbits));
    // ==========================================================
    // monitors, sampled mid cycle so registered pins have settled
    always @(negedge ref_clk) begin
        if (sclk_out !== sclk_q) begin
            hp_last <= hp_cnt;
            hp_cnt <= 16'h0001;
        end else begin
            hp_cnt <= hp_cnt + 16'h0001;
        end
        sclk_q <= sclk_out;
        if (busy && fss_out && frame_fmt == 2'h1) ssf_hi <= 1'b1;
        if (busy && !txd_oe && frame_fmt == 2'h2) cmd_rel <= 1'b1;
        if (rx_overrun) ovr_seen <= 1'b1;
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] fmask(input int n);
        return 16'hffff >> (16 - n);
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // held until the edge where ready is seen high
    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge ref_clk);
        tx_data <= w;
        tx_valid <= 1'b1;
        @(negedge ref_clk);
        while (tx_ready !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 5000) mismatches++;
        @(posedge ref_clk);
        tx_valid <= 1'b0;
    endtask
    task automatic pop(output logic [15:0] w);
        int n;
        n = 0;
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(negedge ref_clk);
        while (rx_valid !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        w = (n < 5000) ? rx_data : 16'hxxxx;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
    endtask
    // one master frame; value checks only in the clock-low early-sample format
    task automatic xfer(input int size, input logic [15:0] w, input logic [15:0] pw,
            input int bits, input logic cmp);
        logic [15:0] r;
        @(posedge ref_clk);
        data_size <= 4'(size - 1);
        peer_len <= 5'(size);
        peer_word <= pw;
        push(w);
        pop(r);
        chk({11'h000, nbits}, 16'(bits));
        if (cmp) begin
            chk(r, pw & fmask(size));
            chk(got & fmask(size), w & fmask(size));
        end
    endtask
    // the bench plays an outside master, half period of four clocks
    task automatic slave_frame(input int size, input logic [15:0] sw, input logic [15:0] tw,
            input logic dis);
        logic [15:0] seen, r;
        logic oe_any;
        int i;
        seen = 16'h0000;
        oe_any = 1'b0;
        @(posedge ref_clk);
        master <= 1'b0;
        slave_out_dis <= dis;
        data_size <= 4'(size - 1);
        push(tw);
        @(posedge ref_clk);
        fss_drv <= 1'b0;
        for (i = size - 1; i >= 0; i--) begin
            rxd_drv <= sw[i];
            repeat (4) @(posedge ref_clk);
            sclk_drv <= 1'b1;
            seen = {seen[14:0], txd_out};
            oe_any = oe_any | txd_oe;
            repeat (4) @(posedge ref_clk);
            sclk_drv <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        fss_drv <= 1'b1;
        pop(r);
        chk(r, sw & fmask(size));
        if (dis) begin
            chk({15'h0000, oe_any}, 16'h0000);
        end else begin
            chk(seen, tw & fmask(size));
        end
        chk({15'h0000, sclk_oe | fss_oe}, 16'h0000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog, well above the expected run of some 4000 clocks
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] wq[16];
        logic [15:0] r;
        logic [7:0] p, q;
        int n;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk({13'h0000, tx_ready, rx_valid, busy}, 16'h0004);
        // every frame size at random rates kept within the peer's reach
        for (n = 4; n <= 16; n++) begin
            p = 8'(1 + rnd() % 3);
            q = 8'(rnd() % 3);
            @(posedge ref_clk);
            prescale <= p;
            rate_div <= q;
            xfer(n, 16'(rnd()), 16'(rnd()), n, 1'b1);
            chk(hp_last, 16'(p * (q + 1)));
        end
        // fill while disabled, then stall the reader so the master must wait
        @(posedge ref_clk);
        enable <= 1'b0;
        prescale <= 8'h01;
        rate_div <= 8'h00;
        data_size <= 4'hf;
        peer_len <= 5'h10;
        peer_word <= 16'ha5c3;
        u_peer.log_q.delete();
        for (n = 0; n < 8; n++) begin
            wq[n] = 16'(rnd());
            push(wq[n]);
        end
        @(negedge ref_clk);
        chk({15'h0000, tx_ready}, 16'h0000);
        @(posedge ref_clk);
        enable <= 1'b1;
        for (n = 8; n < 16; n++) begin
            wq[n] = 16'(rnd());
            push(wq[n]);
        end
        repeat (1000) @(posedge ref_clk);
        chk({15'h0000, busy}, 16'h0000);
        for (n = 0; n < 16; n++) begin
            pop(r);
            chk(r, 16'ha5c3);
            repeat (rnd() % 4) @(posedge ref_clk);
        end
        repeat (200) @(posedge ref_clk);
        chk(16'(u_peer.log_q.size()), 16'h0010);
        for (n = 0; n < 16; n++) begin
            chk(u_peer.log_q[n], wq[n]);
        end
        // slave driving, then slave with its output switched off
        slave_frame(4 + rnd() % 13, 16'(rnd()), 16'(rnd()), 1'b0);
        slave_frame(16, 16'(rnd()), 16'(rnd()), 1'b1);
        // the two other frame formats as master
        @(posedge ref_clk);
        master <= 1'b1;
        for (n = 1; n <= 2; n++) begin
            @(posedge ref_clk);
            frame_fmt <= 2'(n);
            xfer(8, 16'(rnd()), 16'(rnd()), (n == 2) ? 16 : 8, 1'b0);
        end
        chk({14'h0000, ssf_hi, cmd_rel}, 16'h0003);
        chk({15'h0000, ovr_seen}, 16'h0000);
        summarize();
    end
endmodule
